// *** core/dual_position_latch.sv ***
`timescale 1ns/1ps
module dual_position_latch (
    input  wire logic                        pclk,     // Bus clock
    input  wire logic                        presetn,  // Async reset
    input  wire logic                        psel,     // APB select
    input  wire logic                        penable,  // APB enable
    input  wire logic                        pwrite,   // APB direction
    input  wire logic [latch_pkg::ADDR_W-1:0] paddr,   // APB address
    input  wire logic [latch_pkg::DATA_W-1:0] pwdata,  // APB write data
    output logic      [latch_pkg::DATA_W-1:0] prdata,  // APB read data
    output logic                             pready,   // APB ready
    output logic                             pslverr,  // APB error
    input  wire logic [latch_pkg::POS_W-1:0]  machine_position, // Live pos
    input  wire logic                        encoder_index, // Index pin
    input  wire logic [2:0]                  io_connector,  // Probe pins
    output logic                             irq       // Interrupt
);
    import latch_pkg::*;

    // Control and command storage
    logic [31:0] ctrl_q;
    logic [7:0]  cmd_q;

    // Interrupt state
    logic [1:0]  ist_q;
    logic [1:0]  ist_d;
    logic [1:0]  ien_q;
    logic [1:0]  done_prev_q;
    logic [1:0]  done_rise;
    logic        irq_q;

    // Bus response registers
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // Trigger inputs
    logic [3:0]  pins;
    logic [3:0]  pins_s;
    logic [3:0]  pins_prev_q;
    logic [3:0]  trig_rise;

    // Decode wires
    logic        setup;
    logic        wr_en;
    logic        hit_ctrl;
    logic        hit_cmd;
    logic        hit_stat;
    logic        hit_mon1;
    logic        hit_mon2;
    logic        hit_mon3;
    logic        hit_ist;
    logic        hit_ien;
    logic        hit_iclr;
    logic        mapped;
    logic        path_move;
    logic [31:0] stat_word;
    logic [31:0] rd_word;
    logic [1:0]  clr_bits;
    logic [3:0]  mon_code [3];
    logic [31:0] mon_val  [3];

    latch_if lc_a ();
    latch_if lc_b ();

    // Index in bit 0, external inputs 1..3 above it
    assign pins = {io_connector, encoder_index};

    pin_sync #(
        .W(4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pins),
        .q       (pins_s)
    );

    // Edge detect after the synchroniser only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_prev_q <= '0;
        end else begin
            pins_prev_q <= pins_s;
        end
    end

    assign trig_rise = pins_s & ~pins_prev_q;

    // Answer in the first access cycle; setup launches it
    assign setup    = psel & ~penable & ~pready_q;
    assign wr_en    = psel & penable & pready_q & pwrite;
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_cmd  = (paddr == OFS_CMD);
    assign hit_stat = (paddr == OFS_STAT);
    assign hit_mon1 = (paddr == OFS_MON1);
    assign hit_mon2 = (paddr == OFS_MON2);
    assign hit_mon3 = (paddr == OFS_MON3);
    assign hit_ist  = (paddr == OFS_IRQ_ST);
    assign hit_ien  = (paddr == OFS_IRQ_EN);
    assign hit_iclr = (paddr == OFS_IRQ_CLR);
    assign mapped   = hit_ctrl | hit_cmd | hit_stat | hit_mon1
                    | hit_mon2 | hit_mon3 | hit_ist | hit_ien
                    | hit_iclr;

    // Reserved top nibble never stored, reads back zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            cmd_q  <= CMD_RST;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_q <= pwdata & CTRL_WMASK;
            if (hit_cmd) cmd_q <= pwdata[7:0];
        end
    end

    // Requests mean nothing outside the path move command
    assign path_move = (cmd_q == CMD_PATH_MOVE);

    // Independent channel feeds
    assign lc_a.req       = path_move & ctrl_q[REQ_A_BIT];
    assign lc_b.req       = path_move & ctrl_q[REQ_B_BIT];
    assign lc_a.sel       = ctrl_q[SEL_A_LSB +: 2];
    assign lc_b.sel       = ctrl_q[SEL_B_LSB +: 2];
    assign lc_a.trig_rise = trig_rise;
    assign lc_b.trig_rise = trig_rise;
    assign lc_a.position  = machine_position;
    assign lc_b.position  = machine_position;

    latch_channel u_chan_a (
        .pclk    (pclk),
        .presetn (presetn),
        .lc      (lc_a.chan)
    );

    latch_channel u_chan_b (
        .pclk    (pclk),
        .presetn (presetn),
        .lc      (lc_b.chan)
    );

    // Status field with both completion flags
    assign stat_word = ({31'h0, lc_a.done} << DONE_A_BIT)
                     | ({31'h0, lc_b.done} << DONE_B_BIT);

    // Slot codes and what each one shows
    assign mon_code[0] = ctrl_q[MON1_LSB +: 4];
    assign mon_code[1] = ctrl_q[MON2_LSB +: 4];
    assign mon_code[2] = ctrl_q[MON3_LSB +: 4];

    // Unknown codes read zero rather than stale data
    for (genvar i = 0; i < 3; i++) begin : g_mon
        assign mon_val[i] =
            (mon_code[i] == MON_LATCH_A)  ? lc_a.captured :
            (mon_code[i] == MON_LATCH_B)  ? lc_b.captured :
            (mon_code[i] == MON_POSITION) ? machine_position :
            32'h0;
    end

    // Completion edges feed the interrupt status
    assign done_rise = {lc_b.done, lc_a.done} & ~done_prev_q;
    assign clr_bits  = (wr_en & hit_iclr) ? pwdata[1:0] : 2'h0;
    // A new event in the clear cycle survives
    assign ist_d     = (ist_q & ~clr_bits) | done_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_prev_q <= IRQ_RST;
            ist_q       <= IRQ_RST;
            ien_q       <= IRQ_RST;
            irq_q       <= 1'b0;
        end else begin
            done_prev_q <= {lc_b.done, lc_a.done};
            ist_q       <= ist_d;
            if (wr_en && hit_ien) ien_q <= pwdata[1:0];
            irq_q       <= |(ist_d & ien_q);
        end
    end

    // Read selection; clear register reads zero
    assign rd_word =
        hit_ctrl ? ctrl_q :
        hit_cmd  ? {24'h0, cmd_q} :
        hit_stat ? stat_word :
        hit_mon1 ? mon_val[0] :
        hit_mon2 ? mon_val[1] :
        hit_mon3 ? mon_val[2] :
        hit_ist  ? {30'h0, ist_q} :
        hit_ien  ? {30'h0, ien_q} :
        32'h0;

    // Response registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= (setup & ~pwrite) ? rd_word : 32'h0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    // Checks on the top-level behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable && !pready_q;
    endsequence

    sequence s_access;
        psel && penable && pready_q;
    endsequence

    sequence s_pin_one;
        $rose(pins[1]);
    endsequence

    sequence s_trig_a;
        lc_a.armed && lc_a.req && trig_rise[lc_a.sel_used];
    endsequence

    sequence s_done_a_rise;
        lc_a.done && !done_prev_q[0];
    endsequence

    a_resp_next: assert property (s_setup |=> pready_q)
        else $error("setup not answered next cycle");
    a_unmapped_err: assert property ((s_setup and !mapped) |=> pslverr_q)
        else $error("unmapped address without error");
    a_cmd_gate: assert property (!path_move |->
        !lc_a.req && !lc_b.req)
        else $error("request live outside path move");
    a_rsvd_zero: assert property (ctrl_q[31:28] == 4'h0)
        else $error("reserved control bits set");
    a_index_a: assert property (lc_a.armed && lc_a.req &&
        lc_a.sel_used == SRC_INDEX && trig_rise[0] |=> lc_a.done)
        else $error("index trigger missed on channel A");
    a_ext3_b: assert property (lc_b.armed && lc_b.req &&
        lc_b.sel_used == SRC_EXT3 && trig_rise[3] |=> lc_b.done)
        else $error("external input 3 missed on channel B");
    a_done_b_clear: assert property (!lc_b.req && !lc_b.armed |=>
        !lc_b.done)
        else $error("done B not cleared by request drop");
    a_slot_a: assert property (mon_code[0] == MON_LATCH_A |->
        mon_val[0] == lc_a.captured)
        else $error("slot one does not show capture A");
    a_irq_level: assert property (irq_q == |(ist_q & $past(ien_q)))
        else $error("interrupt level wrong");
    a_both_armed: assert property ($rose(lc_a.req) &&
        $rose(lc_b.req) |=> (lc_a.armed || lc_a.done) &&
        (lc_b.armed || lc_b.done))
        else $error("channels not independent");

    // Bus answer shape: one cycle, data only on reads
    a_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("ready held past one cycle");
    a_err_ready: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    a_write_quiet: assert property ((s_setup and pwrite) |=>
        prdata_q == 32'h0)
        else $error("read data driven on a write");
    a_read_word: assert property ((s_setup and !pwrite) |=>
        prdata_q == $past(rd_word))
        else $error("read data not the selected word");
    a_unmapped_rd: assert property ((s_setup and !mapped) |=>
        prdata_q == 32'h0)
        else $error("unmapped read not zero");

    // Stores land at the access edge only
    a_ctrl_store: assert property (
        (s_access and (pwrite && hit_ctrl)) |=>
        ctrl_q == ($past(pwdata) & CTRL_WMASK))
        else $error("control write not stored");
    a_cmd_store: assert property (
        (s_access and (pwrite && hit_cmd)) |=>
        cmd_q == $past(pwdata[7:0]))
        else $error("command write not stored");

    // Status bits: a completion edge always sets, a clear needs no event
    a_ist_set_a: assert property (s_done_a_rise |=> ist_q[0])
        else $error("done A edge missed by status");
    a_ist_set_b: assert property (lc_b.done && !done_prev_q[1] |=>
        ist_q[1])
        else $error("done B edge missed by status");
    a_ist_clear: assert property ((s_access and (pwrite && hit_iclr &&
        pwdata[0] && !done_rise[0])) |=> !ist_q[0])
        else $error("status clear ignored");

    // Probe edge reaches the channels two edges after the pin
    a_pin_sync: assert property (s_pin_one |-> ##2 trig_rise[1])
        else $error("probe input 1 edge lost in sync");

    // Channel behaviour seen from the top, per rule
    a_trig_a: assert property (s_trig_a |=>
        lc_a.done && lc_a.captured == $past(machine_position))
        else $error("channel A trigger not captured");
    a_done_a_clear: assert property (!lc_a.req && !lc_a.armed |=>
        !lc_a.done)
        else $error("done A not cleared by request drop");
    a_done_b_holds: assert property (lc_b.done && lc_b.req |=>
        lc_b.done)
        else $error("done B dropped while request high");
    a_cancel_b: assert property (!lc_b.req |=> !lc_b.armed)
        else $error("request drop left channel B armed");
    a_sel_held_b: assert property (lc_b.req && !$rose(lc_b.req) |=>
        $stable(lc_b.sel_used))
        else $error("channel B selection moved while held");

    // Slot routing; a stale slot would hand the host old data
    a_slot_b: assert property (mon_code[1] == MON_LATCH_B |->
        mon_val[1] == lc_b.captured)
        else $error("slot two does not show capture B");
    a_slot_three: assert property (mon_code[2] == MON_LATCH_A |->
        mon_val[2] == lc_a.captured)
        else $error("slot three does not show capture A");
    a_slot_live: assert property (mon_code[0] == MON_POSITION |->
        mon_val[0] == machine_position)
        else $error("slot one does not show live position");
endmodule

// *** core/latch_channel.sv ***
`timescale 1ns/1ps
module latch_channel (
    input  wire logic pclk,    // Bus clock
    input  wire logic presetn, // Async reset
    latch_if.chan     lc       // Channel link
);
    import latch_pkg::*;

    logic        req_q;
    logic        armed_q;
    logic        armed_d;
    logic        done_q;
    logic        done_d;
    logic [1:0]  sel_q;
    logic [31:0] cap_q;
    logic        req_rise;
    logic        hit;

    // Arm on the request edge; trigger only while armed
    assign req_rise = lc.req & ~req_q;
    assign hit      = armed_q & lc.trig_rise[sel_q];
    // Cancel beats arming; a hit ends the wait
    assign armed_d  = lc.req & (req_rise | (armed_q & ~hit));
    // A hit wins over a same-cycle request drop
    assign done_d   = hit | (done_q & lc.req);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q   <= 1'b0;
            armed_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            req_q   <= lc.req;
            armed_q <= armed_d;
            done_q  <= done_d;
        end
    end

    // Selection frozen at the edge; later edits ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SRC_INDEX;
            cap_q <= '0;
        end else begin
            if (req_rise) sel_q <= lc.sel;
            if (hit) cap_q <= lc.position;
        end
    end

    assign lc.armed    = armed_q;
    assign lc.done     = done_q;
    assign lc.sel_used = sel_q;
    assign lc.captured = cap_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_arm;
        lc.req && !req_q;
    endsequence

    a_arm_on_edge: assert property (s_arm |=> armed_q || done_q)
        else $error("request edge did not arm");
    a_sel_frozen: assert property (!req_rise |=> $stable(sel_q))
        else $error("selection moved without request edge");
    a_capture_pos: assert property (hit |=>
        done_q && cap_q == $past(lc.position))
        else $error("position not captured on trigger");
    a_done_holds: assert property (done_q && lc.req |=> done_q)
        else $error("done dropped while request high");
    a_cancel_drop: assert property (!lc.req && !hit |=>
        !armed_q && !done_q)
        else $error("request low did not cancel");
endmodule

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 4
) (
    input  wire logic         pclk,    // Bus clock
    input  wire logic         presetn, // Async reset
    input  wire logic [W-1:0] d,       // Pin levels
    output logic      [W-1:0] q        // Synced levels
);
    logic [W-1:0] meta_q;

    // Two-stage catch; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// *** shared/latch_if.sv ***
`timescale 1ns/1ps
interface latch_if;
    logic        req;       // Gated request level
    logic [1:0]  sel;       // Live trigger selection
    logic [3:0]  trig_rise; // Source rising pulses
    logic [31:0] position;  // Live machine position
    logic        armed;     // Waiting for trigger
    logic        done;      // Completion flag
    logic [1:0]  sel_used;  // Selection held
    logic [31:0] captured;  // Latched position

    modport chan (
        input  req, sel, trig_rise, position,
        output armed, done, sel_used, captured
    );
    modport ctl (
        output req, sel, trig_rise, position,
        input  armed, done, sel_used, captured
    );
endinterface

// *** shared/latch_pkg.sv ***
package latch_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W  = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CMD     = 8'h04;
    localparam logic [7:0] OFS_STAT    = 8'h08;
    localparam logic [7:0] OFS_MON1    = 8'h0c;
    localparam logic [7:0] OFS_MON2    = 8'h10;
    localparam logic [7:0] OFS_MON3    = 8'h14;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;

    // Control field layout
    localparam int REQ_A_BIT = 8;
    localparam int REQ_B_BIT = 9;
    localparam int SEL_A_LSB = 10;
    localparam int SEL_B_LSB = 12;
    localparam int MON1_LSB  = 16;
    localparam int MON2_LSB  = 20;
    localparam int MON3_LSB  = 24;
    localparam logic [31:0] CTRL_WMASK = 32'h0fff_ffff;

    // Status field layout
    localparam int DONE_A_BIT = 8;
    localparam int DONE_B_BIT = 9;

    // Command codes
    localparam logic [7:0] CMD_PATH_MOVE = 8'h34;

    // Monitor slot codes
    localparam logic [3:0] MON_POSITION = 4'h0;
    localparam logic [3:0] MON_LATCH_A  = 4'h4;
    localparam logic [3:0] MON_LATCH_B  = 4'h5;

    // Trigger source codes
    localparam logic [1:0] SRC_INDEX = 2'h0;
    localparam logic [1:0] SRC_EXT3  = 2'h3;

    // Values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [7:0]  CMD_RST  = 8'h00;
    localparam logic [1:0]  IRQ_RST  = 2'h0;
endpackage

// *** test/dual_position_latch_tb.sv ***
`timescale 1ns/1ps
module dual_position_latch_tb;
    import latch_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] machine_position;
    logic        encoder_index;
    logic [2:0]  io_connector;
    logic [3:0]  fire;
    logic [31:0] pos_set;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          checks;
    int          cyc;

    dual_position_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .machine_position(machine_position), .encoder_index(encoder_index),
        .io_connector(io_connector), .irq(irq));

    probe_model machine (.pclk(pclk), .presetn(presetn), .fire(fire),
        .pos_set(pos_set), .machine_position(machine_position),
        .encoder_index(encoder_index), .io_connector(io_connector));

    // Clock generation
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states are the slave's; only the hang guard ends a wait
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string nm);
        xfer(1'b0, a, 32'h0);
        check(nm, exp, rd);
    endtask

    // Pin p: 0 index, 1..3 external inputs; then let sync and capture land
    task automatic pulse(input int p);
        fire[p] <= 1'b1;
        @(posedge pclk);
        fire <= 4'h0;
        repeat (10) @(posedge pclk);
    endtask

    // Slot one shows A, slot two B, slot three A again
    function automatic logic [31:0] ctl(input logic ra, input logic rb,
                                        input logic [1:0] sa,
                                        input logic [1:0] sb);
        return {4'h0, MON_LATCH_A, MON_LATCH_B, MON_LATCH_A, 2'h0, sb, sa,
                rb, ra, 8'h00};
    endfunction

    // Full latch cycle on one channel; other channel gets another source
    task automatic run(input int ch, input logic [1:0] s);
        logic [31:0] pos;
        pos = 32'h5a5a_0000 | {22'h0, s, 7'h0, ch[0]};
        xfer(1'b1, OFS_CTRL, 32'h0);
        pos_set <= pos;
        xfer(1'b1, OFS_CTRL, ch ? ctl(1'b0, 1'b1, s + 2'h1, s) :
                                  ctl(1'b1, 1'b0, s, s + 2'h1));
        pulse(s);
        rd_chk(OFS_STAT, ch ? 32'h200 : 32'h100, "done");
        pos_set <= ~pos;
        rd_chk(ch ? OFS_MON2 : OFS_MON1, pos, "captured");
        if (ch == 0) rd_chk(OFS_MON3, pos, "slot3");
        check("irq", 32'h1, {31'h0, irq});
        rd_chk(OFS_IRQ_ST, ch ? 32'h2 : 32'h1, "irq status");
        xfer(1'b1, OFS_IRQ_CLR, 32'h3);
        // The cleared level leaves its flop at the same edge as the write
        @(posedge pclk);
        check("irq clr", 32'h0, {31'h0, irq});
        xfer(1'b1, OFS_CTRL, 32'h0);
        rd_chk(OFS_STAT, 32'h0, "done drop");
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, fire} = '0;
        pos_set = 32'h1234_5678;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFS_CTRL, CTRL_RST, "ctrl rst");
        rd_chk(OFS_STAT, 32'h0, "stat rst");
        rd_chk(OFS_MON1, 32'h1234_5678, "live pos");
        xfer(1'b1, OFS_STAT, 32'hffff_ffff);
        rd_chk(OFS_STAT, 32'h0, "stat ro");
        check("no slverr", 32'h0, {31'h0, err});
        xfer(1'b0, 8'h24, 32'h0);
        check("slverr", 32'h1, {31'h0, err});
        check("unmapped rd", 32'h0, rd);
        xfer(1'b1, OFS_CTRL, 32'hffff_0000);
        rd_chk(OFS_CTRL, 32'h0fff_0000, "ctrl mask");
        rd_chk(OFS_MON1, 32'h0, "unknown slot");
        $display("test registers done");
        xfer(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, 2'h1, 2'h2));
        pulse(1);
        rd_chk(OFS_STAT, 32'h0, "no command");
        xfer(1'b1, OFS_CTRL, 32'h0);
        xfer(1'b1, OFS_CMD, {24'h0, CMD_PATH_MOVE});
        xfer(1'b1, OFS_IRQ_EN, 32'h3);
        $display("test gating done");
        for (int s = 0; s < 4; s++) begin
            run(0, s[1:0]);
            run(1, s[1:0]);
        end
        $display("test sources done");
        xfer(1'b1, OFS_IRQ_EN, 32'h0);
        xfer(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, 2'h1, 2'h2));
        xfer(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, 2'h1, 2'h3));
        pulse(3);
        rd_chk(OFS_STAT, 32'h0, "held sel");
        pulse(2);
        rd_chk(OFS_STAT, 32'h200, "held sel hit");
        pulse(1);
        rd_chk(OFS_STAT, 32'h300, "both done");
        pulse(1);
        rd_chk(OFS_STAT, 32'h300, "done stays");
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk(OFS_IRQ_ST, 32'h3, "irq sticky");
        xfer(1'b1, OFS_CTRL, ctl(1'b0, 1'b1, 2'h1, 2'h3));
        rd_chk(OFS_STAT, 32'h200, "drop a");
        $display("test hold done");
        xfer(1'b1, OFS_CTRL, 32'h0);
        xfer(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 2'h1));
        xfer(1'b1, OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 2'h1));
        pulse(0);
        xfer(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 2'h1));
        rd_chk(OFS_STAT, 32'h0, "cancel");
        pulse(0);
        rd_chk(OFS_STAT, 32'h100, "rearm");
        $display("test cancel done");
        print_verdict();
    end
endmodule

// *** test/probe_model.sv ***
`timescale 1ns/1ps
// Machine side: position source and probe pins, pulled low when idle
module probe_model (
    input  wire logic        pclk,             // Bus clock
    input  wire logic        presetn,          // Async reset
    input  wire logic [3:0]  fire,             // One-cycle pulse requests
    input  wire logic [31:0] pos_set,          // Next position
    output logic      [31:0] machine_position, // Live position
    output logic             encoder_index,    // Index pin
    output logic      [2:0]  io_connector      // External inputs 1..3
);
    logic [3:0] sh_q [4];

    // Stretch each request to four cycles, above the two-cycle minimum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) sh_q[i] <= 4'h0;
            machine_position <= 32'h0;
        end else begin
            for (int i = 0; i < 4; i++) sh_q[i] <= {sh_q[i][2:0], fire[i]};
            machine_position <= pos_set;
        end
    end

    // Index plus three external probe inputs
    assign encoder_index = |sh_q[0];
    assign io_connector  = {|sh_q[3], |sh_q[2], |sh_q[1]};
endmodule
